/* File: verilog/bosm_pkg.sv */
package bosm_pkg;
    // Instruction word layout
    localparam int INSTR_W = 14;
    localparam int OPC_W = 6;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int OPC_LSB = 8;
    localparam int DEST_BIT = 7;
    localparam int FADDR_LSB = 0;
    localparam int LIT_LSB = 0;

    // Opcodes, upper six bits of the word
    localparam logic [5:0] OPC_DEC_SKIP = 6'h0B;
    localparam logic [5:0] OPC_INC_SKIP = 6'h0F;
    localparam logic [5:0] OPC_REG_OR = 6'h04;
    localparam logic [5:0] OPC_REG_MOVE = 6'h08;
    localparam logic [5:0] OPC_LIT_OR = 6'h38;

    // Register port map
    localparam int BUS_AW = 8;
    localparam int FILE_SEL_BIT = 7;
    localparam logic [7:0] ADDR_ACC = 8'h80;
    localparam logic [7:0] ADDR_STATUS = 8'h81;
    localparam int STAT_ZERO_BIT = 0;
    localparam int STAT_SKIP_BIT = 1;

    // Reset values
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] FILE_RESET = 8'h00;
    localparam logic ZERO_RESET = 1'b0;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic [7:0] RD_IDLE = 8'h00;

    // Decoded operation
    typedef enum logic [2:0] {
        OP_NONE,
        OP_DEC_SKIP,
        OP_INC_SKIP,
        OP_LIT_OR,
        OP_REG_OR,
        OP_REG_MOVE
    } bosm_op_e;

    typedef logic [7:0] bosm_byte_t;
endpackage

/* File: verilog/bosm_alu_if.sv */
`timescale 1ns/1ns
// Carries one instruction into the datapath and its effects back out
interface bosm_alu_if;
    logic [13:0] instr; // Instruction word
    bosm_pkg::bosm_byte_t acc; // Accumulator value
    bosm_pkg::bosm_byte_t fileVal; // Addressed file register value
    bosm_pkg::bosm_op_e op; // Decoded operation
    bosm_pkg::bosm_byte_t result; // Result byte
    logic writeAcc; // Result goes to accumulator
    logic writeFile; // Result goes to file register
    logic setZero; // Zero flag takes resultZero
    logic resultZero; // Result is zero
    logic skip; // Next instruction becomes idle slot

    modport alu (
        input instr,
        input acc,
        input fileVal,
        output op,
        output result,
        output writeAcc,
        output writeFile,
        output setZero,
        output resultZero,
        output skip
    );
    modport core (
        output instr,
        output acc,
        output fileVal,
        input op,
        input result,
        input writeAcc,
        input writeFile,
        input setZero,
        input resultZero,
        input skip
    );
endinterface

/* File: verilog/bosm_alu.sv */
`timescale 1ns/1ns
// Combinational decode and result for the five byte operations
module bosm_alu (
    bosm_alu_if.alu alu // Datapath carrier
);
    // Opcode field to operation
    function automatic bosm_pkg::bosm_op_e decodeOp(input logic [13:0] w);
        logic [5:0] opc;
        opc = w[bosm_pkg::OPC_LSB +: bosm_pkg::OPC_W];
        unique case (opc)
            bosm_pkg::OPC_DEC_SKIP: decodeOp = bosm_pkg::OP_DEC_SKIP;
            bosm_pkg::OPC_INC_SKIP: decodeOp = bosm_pkg::OP_INC_SKIP;
            bosm_pkg::OPC_LIT_OR: decodeOp = bosm_pkg::OP_LIT_OR;
            bosm_pkg::OPC_REG_OR: decodeOp = bosm_pkg::OP_REG_OR;
            bosm_pkg::OPC_REG_MOVE: decodeOp = bosm_pkg::OP_REG_MOVE;
            default: decodeOp = bosm_pkg::OP_NONE; // Other words leave state
        endcase
    endfunction

    logic destFile; // Target select bit
    logic [7:0] literal; // Eight-bit literal field

    assign destFile = alu.instr[bosm_pkg::DEST_BIT];
    assign literal = alu.instr[bosm_pkg::LIT_LSB +: bosm_pkg::DATA_W];
    assign alu.op = decodeOp(alu.instr);

    // Result, destination and flag effects
    always_comb begin
        alu.result = alu.fileVal;
        alu.writeAcc = 1'b0;
        alu.writeFile = 1'b0;
        alu.setZero = 1'b0;
        alu.skip = 1'b0;
        unique case (alu.op)
            bosm_pkg::OP_DEC_SKIP: begin
                alu.result = alu.fileVal - 8'h01;
                alu.writeAcc = !destFile;
                alu.writeFile = destFile;
                alu.skip = (alu.result == 8'h00); // No flag change
            end
            bosm_pkg::OP_INC_SKIP: begin
                alu.result = alu.fileVal + 8'h01; // Wraps 0xFF to 0
                alu.writeAcc = !destFile;
                alu.writeFile = destFile;
                alu.skip = (alu.result == 8'h00); // No flag change
            end
            bosm_pkg::OP_LIT_OR: begin
                alu.result = alu.acc | literal;
                alu.writeAcc = 1'b1;
                alu.setZero = 1'b1;
            end
            bosm_pkg::OP_REG_OR: begin
                alu.result = alu.acc | alu.fileVal;
                alu.writeAcc = !destFile;
                alu.writeFile = destFile;
                alu.setZero = 1'b1;
            end
            bosm_pkg::OP_REG_MOVE: begin
                // Rewriting the same value keeps the register intact
                alu.result = alu.fileVal;
                alu.writeAcc = !destFile;
                alu.writeFile = destFile;
                alu.setZero = 1'b1; // Zero test of a register
            end
            default: begin
                alu.result = alu.fileVal; // Unknown word does nothing
            end
        endcase
    end

    assign alu.resultZero = (alu.result == 8'h00);
endmodule

/* File: verilog/bosm_exec.sv */
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
module bosm_exec #(
    parameter int FILE_DEPTH = 128 // File registers, addressed 0..127
) (
    input wire logic mclk, // Core clock, 100 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [13:0] instrWord, // Instruction word
    input wire logic instrValid, // Instruction offered this cycle
    input wire logic [7:0] regAddr, // Register port address
    input wire logic [7:0] regWrData, // Register port write data
    input wire logic regWrEn, // Register port write strobe
    input wire logic regRdEn, // Register port read strobe
    output logic [7:0] regRdData, // Read data, cycle after strobe
    output logic [7:0] accOut, // Accumulator
    output logic zeroFlag, // Null result flag
    output logic skipPending, // Next instruction will be idled
    output logic retired, // Pulse: an instruction executed
    output logic idleSlot // Pulse: an instruction was idled
);
    // Address field must cover exactly the file space; a smaller array
    // would let a seven-bit address index past its end
    if (FILE_DEPTH != (1 << bosm_pkg::FADDR_W)) begin : gDepthCheck
        $error("FILE_DEPTH must equal 128");
    end

    // Two states suffice: a skip costs exactly one offered word.
    // No codes are given; the encoding is left to the tool.
    typedef enum {
        ST_RUN, // Instructions execute
        ST_SKIP // Next instruction is replaced by an idle slot
    } bosm_state_e;

    // Architectural state and the pulses that report each word
    bosm_state_e state_q; // Sequencer state
    logic skipPend_q; // Skip armed, own flop so the output is a flop
    logic [7:0] fileMem_q [FILE_DEPTH]; // File registers in flops
    logic [7:0] acc_q; // Accumulator
    logic zero_q; // Null result flag
    logic [7:0] rdData_q; // Read data register
    logic retired_q; // Executed pulse
    logic idleSlot_q; // Idled pulse
    // Decode helpers, all combinational
    logic exec; // Instruction executes now
    logic [6:0] fileIdx; // Instruction file address
    logic [6:0] busIdx; // Bus file address
    logic busFileSel; // Bus address in file space
    logic accSel; // Bus address is the accumulator
    logic statSel; // Bus address is the status byte

    // Register port address matches one named register
    function automatic logic busHit(input logic [7:0] a,
            input logic [7:0] target);
        busHit = (a == target);
    endfunction

    // Status byte from its flag bits; the other bits read as zero
    function automatic logic [7:0] statusByte(input logic z,
            input logic s);
        statusByte = bosm_pkg::RD_IDLE;
        statusByte[bosm_pkg::STAT_ZERO_BIT] = z;
        statusByte[bosm_pkg::STAT_SKIP_BIT] = s;
    endfunction

    // Datapath decode and result, shared through the carrier
    bosm_alu_if aluBus ();

    // Decode and result logic is combinational; every state it
    // changes lives in this module, one flop group per concern
    bosm_alu uAlu (
        .alu (aluBus)
    );

    // Operand fetch: the addressed file register is read straight from
    // its flops, so a word sees the result of the word just before it.
    // Only the low seven bits of the word address the file space.
    assign fileIdx = instrWord[bosm_pkg::FADDR_LSB +: bosm_pkg::FADDR_W];
    assign busIdx = regAddr[bosm_pkg::FADDR_W-1:0];
    assign busFileSel = !regAddr[bosm_pkg::FILE_SEL_BIT];
    assign aluBus.instr = instrWord;
    assign aluBus.acc = acc_q;
    assign aluBus.fileVal = fileMem_q[fileIdx];
    // An offered word executes unless a skip is armed for it
    assign exec = instrValid && (state_q == ST_RUN);

    // Bus decode; file space is every address with the top bit clear
    assign accSel = busHit(regAddr, bosm_pkg::ADDR_ACC);
    assign statSel = busHit(regAddr, bosm_pkg::ADDR_STATUS);

    // Sequencer: a skip turns the next offered word into an idle slot.
    // The armed skip waits for a real word, so gaps in the stream do not
    // use it up; the pending flop mirrors the state for the output pin.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_RUN;
            skipPend_q <= bosm_pkg::FLAG_RESET;
        end else begin
            unique case (state_q)
                ST_RUN: begin
                    // Only the two skip operations raise the skip line
                    if (exec && aluBus.skip) begin
                        state_q <= ST_SKIP;
                        skipPend_q <= 1'b1;
                    end
                end
                ST_SKIP: begin
                    // The offered word is dropped, not executed
                    if (instrValid) begin
                        state_q <= ST_RUN; // Idled word spent
                        skipPend_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    // File registers; the instruction wins over a same-cycle bus write,
    // so software cannot lose a result it has just asked for. A move to
    // itself rewrites the same value and leaves the register intact.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            // Every register clears, so reads after reset are known
            for (int i = 0; i < FILE_DEPTH; i++) begin
                fileMem_q[i] <= bosm_pkg::FILE_RESET;
            end
        end else begin
            if (regWrEn && busFileSel) begin // Bus load of a register
                fileMem_q[busIdx] <= regWrData;
            end
            if (exec && aluBus.writeFile) begin // Later assignment wins
                fileMem_q[fileIdx] <= aluBus.result;
            end
        end
    end

    // Accumulator; as with the file registers, an instruction result
    // overrides a bus load in the same cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= bosm_pkg::ACC_RESET;
        end else begin
            if (regWrEn && accSel) begin // Bus load
                acc_q <= regWrData;
            end
            if (exec && aluBus.writeAcc) begin
                acc_q <= aluBus.result;
            end
        end
    end

    // Null result flag; skip instructions never touch it.
    // Only the zero bit of the status byte loads from the bus; the
    // skip bit is read-only so software cannot cancel a pending skip.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            zero_q <= bosm_pkg::ZERO_RESET;
        end else begin
            if (regWrEn && statSel) begin // Bus load of the zero bit
                zero_q <= regWrData[bosm_pkg::STAT_ZERO_BIT];
            end
            if (exec && aluBus.setZero) begin
                zero_q <= aluBus.resultZero;
            end
        end
    end

    // Execution pulses, one cycle each; an unknown word still retires,
    // which lets a test count every word the core accepted
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            retired_q <= bosm_pkg::FLAG_RESET;
            idleSlot_q <= bosm_pkg::FLAG_RESET;
        end else begin
            retired_q <= exec; // Any executed word
            idleSlot_q <= instrValid && skipPend_q;
        end
    end

    // Read port: data only in the cycle after the strobe, zero otherwise.
    // A read beside an instruction write returns the value before it;
    // the trade is one cycle of staleness for a flop-only output.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_q <= bosm_pkg::RD_IDLE;
        end else if (!regRdEn) begin
            rdData_q <= bosm_pkg::RD_IDLE; // Port idles at zero
        end else if (busFileSel) begin
            rdData_q <= fileMem_q[busIdx]; // Value before this edge
        end else if (accSel) begin
            rdData_q <= acc_q; // Accumulator
        end else if (statSel) begin
            // Zero bit and the read-only skip bit
            rdData_q <= statusByte(zero_q, skipPend_q);
        end else begin
            rdData_q <= bosm_pkg::RD_IDLE; // Unmapped reads zero
        end
    end

    // Outputs straight from flops; nothing combinational reaches a pin,
    // which keeps output timing independent of the decode depth.
    // The skip bit is its own flop rather than a state compare.
    assign regRdData = rdData_q;
    assign accOut = acc_q;
    assign zeroFlag = zero_q;
    assign skipPending = skipPend_q;
    assign retired = retired_q;
    assign idleSlot = idleSlot_q;
endmodule

/* File: bench/bosm_exec_props.sv */
`timescale 1ns/1ns
// Port-level checks of the byte-operation core
module bosm_exec_props #(
    parameter int FILE_DEPTH = 128 // File register count
) (
    input wire logic mclk, // Core clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [13:0] instrWord, // Instruction word
    input wire logic instrValid, // Word offered
    input wire logic regWrEn, // Bus write strobe
    input wire logic [7:0] accOut, // Accumulator
    input wire logic zeroFlag, // Null result flag
    input wire logic skipPending, // Next word idled
    input wire logic retired, // Executed pulse
    input wire logic idleSlot // Idled pulse
);
    // Word that will really execute, and its opcode
    wire logic go = instrValid && !skipPending;
    wire logic [5:0] opc = instrWord[13:8];
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Skipped word: idled pulse only, skip cleared
    sequence s_take;
        instrValid && skipPending;
    endsequence
    property p_idle;
        s_take |=> idleSlot && !retired && !skipPending;
    endproperty
    a_idle: assert property (p_idle) else $error("skip not idled");
    // Bus writes excluded, they may move state legally
    property p_noEffect;
        s_take ##0 !regWrEn |=> $stable(accOut) && $stable(zeroFlag);
    endproperty
    a_noEffect: assert property (p_noEffect) else $error("idled word acted");
    property p_decFlag;
        go && opc == bosm_pkg::OPC_DEC_SKIP && !regWrEn |=> $stable(zeroFlag);
    endproperty
    a_decFlag: assert property (p_decFlag) else $error("flag moved");
    property p_incFlag;
        go && opc == bosm_pkg::OPC_INC_SKIP && !regWrEn |=> $stable(zeroFlag);
    endproperty
    a_incFlag: assert property (p_incFlag) else $error("flag moved");
    // Only the two skip operations may arm a skip
    property p_armSrc;
        $rose(skipPending) |-> $past(go) && ($past(opc) ==
            bosm_pkg::OPC_DEC_SKIP || $past(opc) == bosm_pkg::OPC_INC_SKIP);
    endproperty
    a_armSrc: assert property (p_armSrc) else $error("bad skip source");
    property p_litOr;
        go && opc == bosm_pkg::OPC_LIT_OR |=> accOut == ($past(accOut) |
            $past(instrWord[7:0])) && zeroFlag == (accOut == 8'h00);
    endproperty
    a_litOr: assert property (p_litOr) else $error("literal or wrong");
    // Result keeps every old accumulator bit
    property p_regOr;
        go && opc == bosm_pkg::OPC_REG_OR && !instrWord[7] |=>
            (accOut & $past(accOut)) == $past(accOut) &&
            zeroFlag == (accOut == 8'h00);
    endproperty
    a_regOr: assert property (p_regOr) else $error("register or wrong");
    property p_move;
        go && opc == bosm_pkg::OPC_REG_MOVE && !instrWord[7] |=>
            retired && zeroFlag == (accOut == 8'h00);
    endproperty
    a_move: assert property (p_move) else $error("move flag wrong");
endmodule
bind bosm_exec bosm_exec_props #(.FILE_DEPTH(FILE_DEPTH)) props_u (
    .mclk(mclk), .rst_n(rst_n), .instrWord(instrWord),
    .instrValid(instrValid), .regWrEn(regWrEn), .accOut(accOut),
    .zeroFlag(zeroFlag), .skipPending(skipPending), .retired(retired),
    .idleSlot(idleSlot));

/* File: bench/byte_op_skip_or_move_exec_tb.sv */
`timescale 1ns/1ns
// Random instruction stream checked against a bench model
module byte_op_skip_or_move_exec_tb;
    logic mclk, rst_n, instrValid, regWrEn, regRdEn; // Drives
    logic [13:0] instrWord; // Instruction word
    logic [7:0] regAddr, regWrData, regRdData, accOut; // Bus and acc
    logic zeroFlag, skipPending, retired, idleSlot; // Status outputs
    bit [7:0] fm [128]; // Model file registers
    bit [7:0] ma, r; // Model accumulator, scratch
    bit mz, ms, er, ei; // Model zero, skip, pulses
    int miscompares, checked; // Counters
    bosm_exec dut_u (.mclk(mclk), .rst_n(rst_n), .instrWord(instrWord),
        .instrValid(instrValid), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .accOut(accOut), .zeroFlag(zeroFlag), .skipPending(skipPending),
        .retired(retired), .idleSlot(idleSlot));
    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Compare seen against expected
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("Error t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // One-cycle bus write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge mclk);
        regWrEn <= 1'b0;
    endtask
    // One-cycle bus read, data checked in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge mclk);
        regRdEn <= 1'b0;
        #1 chk(regRdData, e);
    endtask
    // Model of one offered word; w[7] picks accumulator or file, except for the literal or
    task automatic step(input bit [13:0] w);
        er = !ms;
        ei = ms;
        if (ms) begin
            ms = 0;
            return;
        end
        case (w[13:8])
            bosm_pkg::OPC_DEC_SKIP: r = fm[w[6:0]] - 8'h01;
            bosm_pkg::OPC_INC_SKIP: r = fm[w[6:0]] + 8'h01;
            bosm_pkg::OPC_REG_OR: r = ma | fm[w[6:0]];
            bosm_pkg::OPC_REG_MOVE: r = fm[w[6:0]];
            bosm_pkg::OPC_LIT_OR: r = ma | w[7:0];
            default: return;
        endcase
        if (w[13:8] == bosm_pkg::OPC_DEC_SKIP ||
            w[13:8] == bosm_pkg::OPC_INC_SKIP)
            ms = (r == 8'h00);
        else
            mz = (r == 8'h00);
        if (w[7] && w[13:8] != bosm_pkg::OPC_LIT_OR)
            fm[w[6:0]] = r;
        else
            ma = r;
    endtask
    // Verdict and end of run
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        logic [5:0] ops [6];
        bit [13:0] w;
        bit [6:0] f;
        ops = '{bosm_pkg::OPC_DEC_SKIP, bosm_pkg::OPC_INC_SKIP, 6'h00,
            bosm_pkg::OPC_REG_OR, bosm_pkg::OPC_REG_MOVE, bosm_pkg::OPC_LIT_OR};
        {rst_n, instrValid, regWrEn, regRdEn} = 4'h0;
        {instrWord, regAddr, regWrData} = '0;
        void'($urandom(35963));
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        // Seed low and high file registers with edge or random values
        for (int i = 0; i < 16; i++) begin
            f = 7'((i < 8) ? i : 112 + i);
            case ($urandom % 4)
                0: fm[f] = 8'h00;
                1: fm[f] = 8'h01;
                2: fm[f] = 8'hFF;
                default: fm[f] = 8'($urandom);
            endcase
            wr({1'b0, f}, fm[f]);
        end
        // Back-to-back words with random gaps
        for (int i = 0; i <= 600; i++) begin
            f = 7'($urandom % 8 + (($urandom % 4 == 0) ? 120 : 0));
            w = {ops[$urandom % 6], 1'($urandom), f};
            if (w[13:8] == bosm_pkg::OPC_LIT_OR)
                w[7:0] = ($urandom % 3 == 0) ? 8'h00 : 8'($urandom);
            @(posedge mclk);
            instrWord <= w;
            instrValid <= (i < 600) && ($urandom % 4 != 0);
            #1 chk({accOut, zeroFlag, skipPending, retired, idleSlot},
                {ma, mz, ms, er, ei});
            er = 0;
            ei = 0;
            if (instrValid)
                step(w);
        end
        for (int i = 0; i < 16; i++) begin
            f = 7'((i < 8) ? i : 112 + i);
            rd({1'b0, f}, fm[f]);
        end
        rd(8'h80, ma);
        rd(8'h81, {6'h00, ms, mz});
        rd(8'h82, 8'h00);
        close_out();
    end
endmodule
